/* File: rtl/scs_bus_cond.sv */
`timescale 1ns/1ps
module scs_bus_cond (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // bus lines as seen on the wire
  input  wire logic i_scl,
  input  wire logic i_sda,
  // events toward the engine
  scs_cond_if.det   cond
);

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_p;
    logic sda_p;
  } scs_det_t;

  scs_det_t q;
  scs_det_t d;

  // two sample stages give edge and condition detection
  always_comb
  begin
    d       = q;
    d.scl   = i_scl;
    d.sda   = i_sda;
    d.scl_p = q.scl;
    d.sda_p = q.sda;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      q <= 4'hF; // idle bus reads high
    else
      q <= d;
  end

  // sda moving while scl stays high marks start or stop
  assign cond.scl       = q.scl;
  assign cond.sda       = q.sda;
  assign cond.scl_rise  = q.scl & ~q.scl_p;
  assign cond.scl_fall  = ~q.scl & q.scl_p;
  assign cond.start_det = q.scl & q.scl_p & q.sda_p & ~q.sda;
  assign cond.stop_det  = q.scl & q.scl_p & ~q.sda_p & q.sda;

endmodule : scs_bus_cond

/* File: rtl/scs_cond_if.sv */
`timescale 1ns/1ps
// sampled bus lines and condition events from detector to engine
interface scs_cond_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport det (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
  modport eng (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface : scs_cond_if

/* File: rtl/scs_ctrl.sv */
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module scs_ctrl #(
  parameter int unsigned P_LOW_CYC  = scs_pkg::T_LOW_CYC,
  parameter int unsigned P_HIGH_CYC = scs_pkg::T_HIGH_CYC
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // avalon-mm register slave
  input  wire logic [1:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // open-drain scl
  input  wire logic        i_scl,
  output logic             o_scl_o,
  output logic             o_scl_oe,
  // open-drain sda
  input  wire logic        i_sda,
  output logic             o_sda_o,
  output logic             o_sda_oe
);
  import scs_pkg::*;

  localparam logic [15:0] LOW_M1  = 16'(P_LOW_CYC - 1);
  localparam logic [15:0] HIGH_M1 = 16'(P_HIGH_CYC - 1);

  typedef struct packed {
    scs_state_t  st;
    scs_next_t   nx;
    logic        master;
    logic        tx;
    logic        begin_request_flag;
    logic        halt_condition_flag;
    logic        response_needed;
    logic        arb;
    logic        ack;
    logic        si;
    logic [7:0]  shift;
    logic [7:0]  cfg;
    logic        data_wr;
    logic        addr_ph;
    logic        addressed;
    logic        busy;
    logic [3:0]  bitcnt;
    logic [15:0] tcnt;
    logic        hi_seen;
    logic        scl_low;
    logic        sda_low;
    logic        bus_ack;
    logic [31:0] rdata;
  } scs_regs_t;

  scs_regs_t   q;
  scs_regs_t   n;
  scs_cond_if  cond ();

  logic        req;
  logic        wr_go;
  logic [7:0]  wd;
  logic [31:0] rd_mux;
  logic        gen_st;

  // start and stop detection on the sampled wires
  scs_bus_cond u_cond (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_scl  (i_scl),
    .i_sda  (i_sda),
    .cond   (cond.det)
  );

  // next frame after a stall or an ack: stop, restart or a new byte
  function automatic scs_regs_t begin_frame(input scs_regs_t s);
    scs_regs_t r;
    r         = s;
    r.tcnt    = 16'h0000;
    r.hi_seen = 1'b0;
    r.scl_low = s.master;
    if (s.master && s.halt_condition_flag)
    begin
      r.st      = ST_M_STOP; // R3
      r.sda_low = 1'b1;
    end
    else if (s.master && s.begin_request_flag)
    begin
      r.st      = ST_M_RSTART;
      r.sda_low = 1'b0;
    end
    else
    begin
      r.st      = ST_BITS;
      r.tx      = s.data_wr; // R17
      r.data_wr = 1'b0;
      r.bitcnt  = 4'h0;
      r.sda_low = s.data_wr & ~s.shift[7]; // R20
    end
    return r;
  endfunction : begin_frame

  // lost arbitration drops the controller role and flags it
  function automatic scs_regs_t lose(input scs_regs_t s);
    scs_regs_t r;
    r         = s;
    r.arb     = 1'b1; // R11 R13
    r.si      = 1'b1; // R14
    r.master  = 1'b0; // R16
    r.tx      = 1'b0; // R17
    r.st      = ST_IGNORE;
    r.scl_low = 1'b0;
    r.sda_low = 1'b0;
    return r;
  endfunction : lose

  // bus request decode and read data
  assign req    = i_avs_read | i_avs_write;
  assign wr_go  = i_avs_write & q.bus_ack & i_avs_byteenable[0];
  assign wd     = i_avs_writedata[7:0];
  assign gen_st = (q.st == ST_M_START) || (q.st == ST_M_RSTART);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (i_avs_address)
      IDX_CTRL: rd_mux[7:0] = {q.master, q.tx, q.begin_request_flag, q.halt_condition_flag, // R1 R5
                               q.response_needed, q.arb, q.ack, q.si};
      IDX_DATA: rd_mux[7:0] = q.shift;
      IDX_CFG:  rd_mux[7:0] = (q.cfg & CFG_WMASK) | (8'(q.busy) << CFG_BUSY);
      default:  rd_mux      = 32'h0000_0000;
    endcase
  end

  // register access, bus engine and hardware flag updates
  always_comb
  begin
    n         = q;
    n.bus_ack = req & ~q.bus_ack;
    if (i_avs_read && !q.bus_ack)
      n.rdata = rd_mux;

    // software writes come first so hardware sets win
    if (wr_go)
    begin
      unique case (i_avs_address)
        IDX_CTRL:
        begin
          n.begin_request_flag = wd[BIT_STA]; // R2
          n.halt_condition_flag = wd[BIT_STO];
          n.ack = wd[BIT_ACK]; // R6 R9
          if (q.si && !wd[BIT_SI])
          begin
            n.si  = 1'b0; // R15
            n.arb = 1'b0; // R11 R23
          end
        end
        IDX_DATA:
        begin
          n.shift   = wd; // R19
          n.data_wr = 1'b1;
        end
        IDX_CFG:  n.cfg = wd & CFG_WMASK;
        default:  n.cfg = q.cfg;
      endcase
    end

    if (cond.start_det)
      n.busy = 1'b1;
    if (cond.stop_det)
      n.busy = 1'b0;

    // scl timing for the controller while shifting bits
    if (q.master && (q.st == ST_BITS || q.st == ST_ACK))
    begin
      n.tcnt = q.tcnt + 16'h0001;
      if (q.scl_low)
      begin
        if (q.tcnt == LOW_M1)
        begin
          n.scl_low = 1'b0;
          n.tcnt    = 16'h0000;
        end
      end
      else if (!cond.scl)
        n.tcnt = 16'h0000; // stretched by another device
      else if (q.tcnt == HIGH_M1)
      begin
        n.scl_low = 1'b1;
        n.tcnt    = 16'h0000;
      end
    end

    unique case (q.st)
      ST_IDLE:
      begin
        n.scl_low = 1'b0;
        n.sda_low = 1'b0;
        if (q.busy)
          n.tcnt = 16'h0000;
        else if (q.tcnt != HIGH_M1)
          n.tcnt = q.tcnt + 16'h0001;
        else if (q.begin_request_flag && q.cfg[CFG_EN])
        begin
          n.st      = ST_M_START; // R2 R4
          n.tcnt    = 16'h0000;
          n.sda_low = 1'b1;
        end
      end
      ST_M_START:
      begin
        n.sda_low = 1'b1;
        n.tcnt    = q.tcnt + 16'h0001;
        if (q.tcnt == HIGH_M1)
        begin
          n.scl_low = 1'b1;
          n.master  = 1'b1; // R16
          n.tx      = 1'b1; // R17
          n.si      = 1'b1; // R14
          n.st      = ST_HOLD;
          n.nx      = NX_FRAME;
          n.tcnt    = 16'h0000;
        end
      end
      ST_M_RSTART, ST_M_STOP:
      begin
        n.tcnt = q.tcnt + 16'h0001;
        if (q.scl_low)
        begin
          n.sda_low = (q.st == ST_M_STOP);
          if (q.tcnt == LOW_M1)
          begin
            n.scl_low = 1'b0;
            n.tcnt    = 16'h0000;
            n.hi_seen = 1'b0;
          end
        end
        else if (!cond.scl)
        begin
          n.tcnt = 16'h0000;
          if (q.hi_seen)
            n = lose(n); // R12
        end
        else
        begin
          n.hi_seen = 1'b1;
          if (q.tcnt == HIGH_M1)
          begin
            n.tcnt = 16'h0000;
            if (q.st == ST_M_STOP)
            begin
              n.sda_low = 1'b0;
              n.halt_condition_flag     = 1'b0; // R3
              n.master  = 1'b0; // R16
              n.st      = ST_IDLE; // R4
            end
            else
            begin
              n.sda_low = 1'b1;
              n.st      = ST_M_START;
            end
          end
        end
      end
      ST_BITS:
      begin
        if (cond.scl_rise)
        begin
          n.shift = {q.shift[6:0], cond.sda}; // R20 R21
          if (q.tx && !q.sda_low && !cond.sda)
            n = lose(n); // R12 R13
        end
        else if (cond.scl_fall)
        begin
          n.bitcnt  = q.bitcnt + 4'h1;
          n.sda_low = q.tx & ~q.shift[7]; // R20
          if (q.bitcnt == BITS_LAST)
          begin
            n.bitcnt  = 4'h0;
            n.sda_low = 1'b0;
            if (q.tx)
              n.st = ST_ACK; // R22
            else
            begin
              n.si    = 1'b1; // R14 R22
              n.response_needed = 1'b1; // R7
              n.ack   = 1'b0; // R8
              n.st    = ST_HOLD;
              n.nx    = NX_ACK;
              if (q.addr_ph)
                n.begin_request_flag = 1'b1; // R18
            end
          end
        end
      end
      ST_ACK:
      begin
        n.sda_low = ~q.tx & q.ack;
        if (q.tx && cond.scl_rise)
          n.ack = ~cond.sda; // R6
        if (cond.scl_fall)
        begin
          n.sda_low = 1'b0;
          if (q.tx)
          begin
            n.si      = 1'b1; // R14 R22
            n.st      = ST_HOLD;
            n.nx      = NX_FRAME;
            n.scl_low = 1'b1;
          end
          else
          begin
            n.response_needed   = 1'b0; // R7
            n.addr_ph = 1'b0;
            if (q.addr_ph && !q.ack)
            begin
              n.st      = ST_IGNORE; // R10
              n.scl_low = 1'b0;
            end
            else
            begin
              n.addressed = q.addressed | q.addr_ph;
              n           = begin_frame(n); // R3
            end
          end
        end
      end
      ST_HOLD:
      begin
        n.scl_low = 1'b1; // R15
        if (q.response_needed)
          n.sda_low = q.ack; // R9
        if (!q.si)
        begin
          unique case (q.nx)
            NX_ACK:
            begin
              n.st      = ST_ACK;
              n.tcnt    = 16'h0000;
              n.scl_low = q.master;
            end
            NX_IGNORE:
            begin
              n.st      = ST_IGNORE;
              n.scl_low = 1'b0;
              n.sda_low = 1'b0;
            end
            NX_FRAME: n = begin_frame(n);
            default:  n.st = ST_IGNORE;
          endcase
        end
      end
      ST_IGNORE:
      begin
        n.scl_low = 1'b0;
        n.sda_low = 1'b0;
        if (!q.busy)
          n.st = ST_IDLE;
      end
      default: n.st = ST_IDLE;
    endcase

    // conditions made by other devices on the bus
    if (cond.start_det && !gen_st)
    begin
      if (q.master)
      begin
        if (!q.begin_request_flag)
          n = lose(n); // R12
      end
      else if (q.cfg[CFG_EN])
      begin
        n.tx        = 1'b0; // R17
        n.bitcnt    = 4'h0;
        n.addressed = 1'b0;
        n.scl_low   = 1'b0;
        n.sda_low   = 1'b0;
        n.addr_ph   = ~q.cfg[CFG_INH];
        n.st        = q.cfg[CFG_INH] ? ST_IGNORE : ST_BITS; // R10
      end
    end
    if (cond.stop_det && q.st != ST_M_STOP)
    begin
      if (q.master)
      begin
        n     = lose(n); // R12
        n.halt_condition_flag = 1'b1; // R18
      end
      else
      begin
        if (q.addressed)
        begin
          n.halt_condition_flag = 1'b1; // R18
          n.si  = 1'b1; // R14
        end
        n.addressed = 1'b0;
        n.addr_ph   = 1'b0;
        n.response_needed     = 1'b0;
        n.st        = ST_IDLE;
        n.scl_low   = 1'b0;
        n.sda_low   = 1'b0;
      end
    end

    // a disabled interface releases the bus and forgets its role
    if (!q.cfg[CFG_EN])
    begin
      n.st      = ST_IDLE;
      n.master  = 1'b0;
      n.scl_low = 1'b0;
      n.sda_low = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      q <= '0; // all flags, state idle, reset values zero
    else
      q <= n;
  end

  // outputs: pins pull low only
  assign o_avs_readdata    = q.rdata;
  assign o_avs_waitrequest = req & ~q.bus_ack;
  assign o_scl_o           = 1'b0;
  assign o_scl_oe          = q.scl_low;
  assign o_sda_o           = 1'b0;
  assign o_sda_oe          = q.sda_low;

endmodule : scs_ctrl

/* File: rtl/scs_pkg.sv */
// Summary of operation
// R1 - upper four control bits form status vector
// R2 - begin request starts controller start, stays set
// R3 - halt flag sends stop after ack, clears
// R4 - both flags: stop then start
// R5 - begin/halt flags report seen start/stop
// R6 - handshake bit: outgoing ack or received ack
// R7 - response needed after byte received, cleared after ack
// R8 - no handshake write means not-acknowledge sent
// R9 - sda shows ack at once, scl held low
// R10 - nacked address ignores slave events until start
// R11 - contention lost set on loss, cleared with pending
// R12 - four loss cases: restart, stop, scl low, sda low
// R13 - slave loss is bus error, flagged as lost
// R14 - pending flag set on the five bus events
// R15 - pending flag holds scl low until software clears; a loss or a received stop sets it with scl released
// R16 - controller role set on start, cleared stop/loss
// R17 - transmit direction follows start and byte write
// R18 - begin flag on address, halt flag on stop
// R19 - software touches byte register only while pending; the data index takes writes at any time
// R20 - byte shifts msb first, first bit to msb
// R21 - bus data always shifts into byte register
// R22 - interrupt after ack transmitting, before receiving
// R23 - read-only indicator bits ignore software writes
package scs_pkg;

  // register word indexes on the avalon slave
  localparam logic [1:0] IDX_CTRL = 2'h0;
  localparam logic [1:0] IDX_DATA = 2'h1;
  localparam logic [1:0] IDX_CFG  = 2'h2;

  // control/status field positions
  localparam int BIT_SI     = 0;
  localparam int BIT_ACK    = 1;
  localparam int BIT_ARB    = 2;
  localparam int BIT_RESPONSE_NEEDED  = 3;
  localparam int BIT_STO    = 4;
  localparam int BIT_STA    = 5;
  localparam int BIT_TX     = 6;
  localparam int BIT_MASTER = 7;

  // configuration field positions
  localparam int CFG_EN   = 0;
  localparam int CFG_INH  = 1;
  localparam int CFG_BUSY = 5;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'h03;

  // timing of generated scl, in ns and in clock cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_LOW_NS      = 5000;
  localparam int T_HIGH_NS     = 5000;
  localparam int T_LOW_CYC     = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_HIGH_CYC    = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] BITS_LAST = 4'h7;

  // engine states and what follows a stall
  typedef enum logic [3:0] {
    ST_IDLE, ST_M_START, ST_M_RSTART, ST_M_STOP, ST_BITS, ST_ACK, ST_HOLD, ST_IGNORE
  } scs_state_t;

  typedef enum logic [1:0] {NX_FRAME, NX_ACK, NX_IGNORE} scs_next_t;

endpackage : scs_pkg

/* File: tb/scs_bus_model.sv */
`timescale 1ns/1ps
module scs_bus_model #(
  parameter logic [6:0] P_ADDR = 7'h2A
) (
  // clock and bus lines
  input  wire logic       i_clk,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  // commands
  input  wire logic       i_jam,
  input  wire logic [7:0] i_tx_byte,
  // results
  output logic            o_sda_oe,
  output logic [7:0]      o_rx_byte,
  output logic            o_rx_stb
);
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic       act   = 1'b0;
  logic       adr   = 1'b0;
  logic       rd    = 1'b0;
  logic       mnack = 1'b0;
  logic       drv   = 1'b0;
  logic       jam_q = 1'b0;
  logic       pre   = 1'b0; // start's own scl fall still to come
  logic [3:0] bit_n = 4'h0;
  logic [7:0] sh    = 8'h00;
  logic [7:0] tx    = 8'h00;
  // a jam pulls sda low from the next scl fall until released
  assign o_sda_oe = drv | jam_q;
  // behavioural slave sampled on the system clock
  always @(posedge i_clk)
  begin
    scl_q    <= i_scl;
    sda_q    <= i_sda;
    o_rx_stb <= 1'b0;
    if (!i_jam)
      jam_q <= 1'b0;
    if (i_scl && scl_q && sda_q && !i_sda)
    begin
      act   <= 1'b1;
      adr   <= 1'b1;
      mnack <= 1'b0;
      bit_n <= 4'h0;
      drv   <= 1'b0;
      pre   <= 1'b1;
    end
    else if (i_scl && scl_q && !sda_q && i_sda)
    begin
      act <= 1'b0;
      drv <= 1'b0;
    end
    else if (act && i_scl && !scl_q)
    begin
      if (bit_n < 4'h8)
        sh <= {sh[6:0], i_sda};
      else
        mnack <= i_sda;
    end
    else if (act && !i_scl && scl_q && pre)
    begin
      jam_q <= i_jam; // the fall that ends a start is not a bit
      pre   <= 1'b0;
    end
    else if (act && !i_scl && scl_q)
    begin
      jam_q <= i_jam;
      bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
      if (bit_n == 4'h7 && adr)
      begin
        drv <= sh[7:1] == P_ADDR;
        act <= sh[7:1] == P_ADDR;
        rd  <= sh[0];
        adr <= 1'b0;
      end
      else if (bit_n == 4'h7)
      begin
        drv       <= !rd;
        o_rx_byte <= sh;
        o_rx_stb  <= !rd;
      end
      else if (bit_n == 4'h8)
      begin
        tx  <= {i_tx_byte[6:0], 1'b0};
        drv <= rd && !mnack && !i_tx_byte[7];
        act <= !(rd && mnack);
      end
      else
      begin
        tx  <= {tx[6:0], 1'b0};
        drv <= rd && !adr && !tx[7];
      end
    end
  end
endmodule : scs_bus_model

/* File: tb/scs_checker.sv */
`timescale 1ns/1ps
module scs_checker #(
  parameter int unsigned P_LOW_CYC = 4
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // register slave
  input  wire logic [1:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [31:0] o_avs_readdata,
  input  wire logic        o_avs_waitrequest,
  // bus drivers
  input  wire logic        o_scl_o,
  input  wire logic        o_scl_oe,
  input  wire logic        o_sda_o,
  input  wire logic        o_sda_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic       rd_c;
  logic       wr_c;
  logic       wr_ctl;
  logic       pend_q;
  logic       rq_q;
  logic       en_q;
  logic       clr_q;
  logic [7:0] lo_q;
  // completed accesses
  assign rd_c   = i_avs_read && !o_avs_waitrequest;
  assign wr_c   = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign wr_ctl = wr_c && i_avs_address == 2'h0;
  // shadow of what software has seen and length of each scl low phase
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      {pend_q, rq_q, en_q, clr_q} <= 4'h0;
      lo_q <= 8'h00;
    end
    else
    begin
      if (rd_c && i_avs_address == 2'h0)
      begin
        pend_q <= o_avs_readdata[0] && o_avs_readdata[7];
        rq_q   <= o_avs_readdata[3];
      end
      else if (wr_ctl && !i_avs_writedata[0])
        pend_q <= 1'b0;
      if (wr_ctl && !i_avs_writedata[0])
        clr_q <= 1'b1;
      else if (rd_c)
        clr_q <= 1'b0;
      if (wr_c && i_avs_address == 2'h2)
        en_q <= i_avs_writedata[0];
      lo_q <= o_scl_oe ? ((lo_q == 8'hFF) ? lo_q : lo_q + 8'h01) : 8'h00;
    end
  wait_one_a: assert property (($rose(i_avs_read) || $rose(i_avs_write))
    |-> o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("wait cycle count wrong");
  rd_upper_a: assert property (rd_c |-> o_avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  unmapped_a: assert property (rd_c && i_avs_address == 2'h3 |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  open_drain_a: assert property (!o_scl_o && !o_sda_o) else $error("open drain level high");
  idle_off_a: assert property (!en_q |-> !o_scl_oe && !o_sda_oe) else $error("bus driven while off");
  stall_hold_a: assert property (pend_q |-> o_scl_oe) else $error("scl released while pending");
  ack_drive_a: assert property (wr_ctl && i_avs_writedata[1:0] == 2'h3 && rq_q
    |-> ##[1:2] o_sda_oe && o_scl_oe) else $error("ack not driven on write");
  arb_clear_a: assert property (rd_c && i_avs_address == 2'h0 && clr_q
    |-> !o_avs_readdata[2]) else $error("lost flag kept after clear");
  ack_rx_a: assert property (rd_c && i_avs_address == 2'h0 && o_avs_readdata[3]
    |-> !o_avs_readdata[6]) else $error("response needed while sending");
  loss_role_a: assert property (rd_c && i_avs_address == 2'h0 && o_avs_readdata[2]
    |-> !o_avs_readdata[7]) else $error("controller role kept after loss");
  scl_low_a: assert property ($fell(o_scl_oe) |-> lo_q >= P_LOW_CYC - 1)
    else $error("scl low phase too short");
endmodule : scs_checker

/* File: tb/scs_ctrl_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module scs_ctrl_test;
  import scs_pkg::*;
  typedef struct packed {logic [7:0] exp; logic [7:0] msk;} scs_note_t;
  logic        i_clk  = 1'b0;
  logic        i_nrst = 1'b0;
  logic [1:0]  adr    = 2'h0;
  logic        rd     = 1'b0;
  logic        wr     = 1'b0;
  logic [31:0] wd     = 32'h0;
  logic        jam    = 1'b0;
  logic [7:0]  txb    = 8'h00;
  logic [31:0] rdata;
  logic        wreq, scl_oe, sda_oe, m_oe, rx_stb;
  logic [7:0]  rxb;
  wire         scl_w = !scl_oe;
  wire         sda_w = !(sda_oe || m_oe);
  int          failures  = 0;
  int          cmp_count = 0;
  scs_note_t   rq[$];
  scs_note_t   nt;
  logic [7:0]  mq[$];
  always #50 i_clk = ~i_clk;
  scs_ctrl #(.P_LOW_CYC(4), .P_HIGH_CYC(4)) uut (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_scl(scl_w),
    .o_scl_o(), .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda_o(), .o_sda_oe(sda_oe));
  scs_bus_model #(.P_ADDR(7'h2A)) peer (.i_clk(i_clk), .i_scl(scl_w), .i_sda(sda_w),
    .i_jam(jam), .i_tx_byte(txb), .o_sda_oe(m_oe), .o_rx_byte(rxb), .o_rx_stb(rx_stb));
  // one bus cycle, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    adr <= a;
    wd  <= {24'h0, d};
    rd  <= !w;
    wr  <= w;
    do
    begin
      @(negedge i_clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    @(posedge i_clk);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
      failures++;
  endtask : acc
  task automatic wrt(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask : wrt
  task automatic rdchk(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] q;
    rq.push_back('{e, m});
    acc(1'b0, a, 8'h00, q);
  endtask : rdchk
  // poll a register until the masked value appears
  task automatic waitv(input logic [1:0] a, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] q;
    int k;
    k = 0;
    do
    begin
      rq.push_back('{8'h00, 8'h00});
      acc(1'b0, a, 8'h00, q);
      k++;
    end
    while ((q & m) !== v && k < 300);
    if ((q & m) !== v)
      failures++;
  endtask : waitv
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  // takes the oldest note whenever read data appears and the oldest expected byte whenever a received byte appears
  always @(posedge i_clk)
  begin
    if (rd && !wreq && rq.size() > 0)
    begin
      nt = rq.pop_front();
      if (nt.msk != 8'h00)
        `CHK(rdata[7:0] & nt.msk, nt.exp & nt.msk)
    end
    if (rx_stb && mq.size() > 0)
      `CHK(rxb, mq.pop_front())
  end
  // watchdog
  initial
  begin
    #2000000;
    failures++;
    results();
  end
  initial
  begin
    logic [7:0] d;
    void'($urandom(32'h57a456ba));
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    rdchk(2'h0, 8'h00, 8'hFF);
    rdchk(2'h1, 8'h00, 8'hFF);
    rdchk(2'h2, 8'h00, 8'hFF);
    wrt(2'h0, 8'hCC);
    rdchk(2'h0, 8'h00, 8'hFF);
    wrt(2'h3, 8'h5A);
    rdchk(2'h3, 8'h00, 8'hFF);
    d = 8'($urandom);
    wrt(2'h1, d);
    rdchk(2'h1, d, 8'hFF);
    $display("registers done");
    wrt(2'h2, 8'h01);
    wrt(2'h0, 8'h20);
    waitv(2'h0, 8'h01, 8'h01);
    rdchk(2'h0, 8'hE1, 8'hFD);
    wrt(2'h1, 8'h54);
    wrt(2'h0, 8'h00);
    waitv(2'h0, 8'h01, 8'h01);
    rdchk(2'h0, 8'hC3, 8'hFF);
    rdchk(2'h1, 8'h54, 8'hFF);
    d = 8'($urandom);
    mq.push_back(d);
    wrt(2'h1, d);
    wrt(2'h0, 8'h00);
    waitv(2'h0, 8'h01, 8'h01);
    rdchk(2'h0, 8'hC3, 8'hFF);
    wrt(2'h0, 8'h10);
    waitv(2'h0, 8'h80, 8'h00);
    rdchk(2'h0, 8'h00, 8'h90);
    $display("controller write done");
    wrt(2'h0, 8'h20);
    waitv(2'h0, 8'h01, 8'h01);
    wrt(2'h1, 8'hAA);
    wrt(2'h0, 8'h00);
    waitv(2'h0, 8'h01, 8'h01);
    rdchk(2'h0, 8'hC1, 8'hFF);
    wrt(2'h0, 8'h30);
    waitv(2'h0, 8'h01, 8'h01);
    rdchk(2'h0, 8'hE1, 8'hFD);
    $display("refused address done");
    d = 8'($urandom);
    @(posedge i_clk) txb <= d;
    wrt(2'h1, 8'h55);
    wrt(2'h0, 8'h00);
    waitv(2'h0, 8'h01, 8'h01);
    rdchk(2'h0, 8'hC3, 8'hFF);
    wrt(2'h0, 8'h00);
    waitv(2'h0, 8'h01, 8'h01);
    rdchk(2'h0, 8'h89, 8'hFF);
    rdchk(2'h1, d, 8'hFF);
    wrt(2'h0, 8'h03);
    repeat (2) @(negedge i_clk);
    `CHK(sda_oe && scl_oe, 1'b1)
    wrt(2'h0, 8'h02);
    waitv(2'h0, 8'h01, 8'h01);
    rdchk(2'h0, 8'h89, 8'hFF);
    rdchk(2'h1, d, 8'hFF);
    wrt(2'h0, 8'h10);
    waitv(2'h0, 8'h80, 8'h00);
    rdchk(2'h0, 8'h00, 8'h98);
    $display("controller read done");
    @(posedge i_clk) jam <= 1'b1;
    wrt(2'h0, 8'h20);
    waitv(2'h0, 8'h01, 8'h01);
    wrt(2'h1, 8'hFF);
    wrt(2'h0, 8'h00);
    waitv(2'h0, 8'h01, 8'h01);
    rdchk(2'h0, 8'h05, 8'hCD);
    @(posedge i_clk) jam <= 1'b0;
    wrt(2'h0, 8'h00);
    rdchk(2'h0, 8'h00, 8'h05);
    $display("lost contention done");
    results();
  end
endmodule : scs_ctrl_test
bind scs_ctrl scs_checker #(.P_LOW_CYC(P_LOW_CYC)) chk (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_scl_o(o_scl_o),
  .o_scl_oe(o_scl_oe), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe));
